// *** adc_queue_sequencer.sv ***
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
`include "sequencer_consts.svh"
// ==========================================================================
// Functional notes
// [R01] one shared 40-word command table feeds both queues
// [R02] queue 1 always wins the converter over queue 2
// [R03] with both queues inactive, a triggered queue starts
// [R04] queue 2 triggered under running queue 1 waits as pending
// [R05] extra queue 2 triggers while pending count as overrun
// [R06] queue 1 trigger aborts running queue 2 and suspends it
// [R07] queue 2 triggers while suspended count as overrun
// [R08] suspended queue 2 resumes after queue 1; resume bit picks word
// [R09] simultaneous triggers start queue 1, queue 2 goes pending
// [R10] pause bit ends a subqueue; queue mode picks trigger kind
// [R11] single or continuous scan applies to the whole queue
// [R12] subqueue words run in order, then pause; no subqueue repeats
// [R13] triggers during a running subqueue only set overrun
// [R14] continuous scan restarts at first word after completion
// [R15] after a pause word converts: pause flag, paused, await trigger
// [R16] channel 63 first: completion flag, idle, no conversion
// [R17] queue 2 begin beyond table end gives immediate end of queue
// [R18] queue 1 ends at queue 2 begin word; begin at 0 ends at once
// [R19] coincident end conditions behave as one
// [R20] pause then end: convert, set pause and completion, idle
// [R21] pause and end in one word: end wins, no conversion
// [R22] disabled or reserved mode keeps queue inactive, ignores triggers
// [R23] both queues disabled: table accesses get no extra wait
// [R24] software changes prescaler only with queues disabled
// [R25] per-queue sticky flags stay set until software clears them
module adc_queue_sequencer (
  // clock, reset, enable
  input  logic                        clock,
  input  logic                        nrst,
  input  logic                        ce,
  // avalon-mm register slave
  input  sequencer_pkg::avs_req_type  avs_req,
  output sequencer_pkg::avs_rsp_type  avs_rsp,
  // trigger pins, asynchronous
  input  logic                        trig1,
  input  logic                        trig2,
  // converter handshake
  output sequencer_pkg::conv_cmd_type conv,
  input  logic                        conv_done,
  input  sequencer_pkg::result_type   conv_result
);
  import sequencer_pkg::*;

  state_type   s;
  state_type   n;
  queue_type   qn;
  queue_type   cur_q;
  ccw_type     cur_cw;
  logic        cur_eoq;
  logic        ev1;
  logic        ev2;
  logic        req;
  logic        tbl;
  logic        acc;
  logic [31:0] rd;
  logic [6:0]  roff;

  // ========================================================================
  // decoding helpers
  function automatic logic mode_ok(input logic [2:0] m);
    return m inside {`MODE_SW_SINGLE, `MODE_EX_SINGLE, `MODE_SW_CONT, `MODE_EX_CONT};
  endfunction

  // trigger kind depends on the queue mode, never on the subqueue
  function automatic logic trig_event(input queue_type q, input logic hit);
    logic rest;
    rest = (q.st == q_idle) || (q.st == q_paused);
    case (q.mode)
      `MODE_SW_SINGLE: trig_event = q.sse && rest;   // see [R10] see [R11]
      `MODE_EX_SINGLE: trig_event = q.sse && hit;
      `MODE_SW_CONT:   trig_event = rest;
      `MODE_EX_CONT:   trig_event = hit;
      default:         trig_event = 1'b0;            // see [R22]
    endcase
  endfunction

  // any end condition gives the same result
  function automatic logic is_eoq(input logic q2, input ptr_type p, input ccw_type cw,
                                  input ptr_type b);
    return (p >= `TBL_END)                            // see [R17]
        || (cw[`CCW_CHAN] == `EOQ_CODE)               // see [R16]
        || (!q2 && p == b);                           // see [R18] see [R19]
  endfunction

  // stop the engine; converter told to drop a running conversion
  function automatic state_type abort_run(input state_type x, input logic was_conv);
    state_type y;
    y = x;
    y.cmd.abort = was_conv;
    y.cmd.start = 1'b0;
    y.eng = e_idle;
    y.after_pause = 1'b0;
    return y;
  endfunction

  // ========================================================================
  // shared views of the running queue
  assign cur_q   = s.run2 ? s.q2 : s.q1;
  assign cur_cw  = (cur_q.ptr < `TBL_END) ? s.conversion_command_word[cur_q.ptr] : '0;   // see [R01]
  assign cur_eoq = is_eoq(s.run2, cur_q.ptr, cur_cw, s.bq2);
  assign ev1     = trig_event(s.q1, s.t1 & ~s.t1d);
  assign ev2     = trig_event(s.q2, s.t2 & ~s.t2d);

  // bus decode; tables stall only while the engine owns them
  assign req = avs_req.read | avs_req.write;
  assign tbl = (avs_req.address < `ADR_CCW_END)
            || (avs_req.address >= `ADR_RES && avs_req.address < `ADR_RES_END);
  assign acc = req && s.rsp.waitrequest && !(tbl && s.eng != e_idle);   // see [R23]

  // ========================================================================
  // read data mux
  always_comb begin
    rd = '0;
    roff = avs_req.address - `ADR_RES;
    if (avs_req.address < `ADR_CCW_END) begin
      rd[`CCW_BITS] = s.conversion_command_word[avs_req.address[5:0]];
    end else if (avs_req.address >= `ADR_RES && avs_req.address < `ADR_RES_END) begin
      rd[`RES_BITS] = s.res[roff[5:0]];
    end else if (avs_req.address == `ADR_Q1CTL) begin
      rd[`CTL_MODE] = s.q1.mode;
    end else if (avs_req.address == `ADR_Q2CTL) begin
      rd[`CTL_MODE]   = s.q2.mode;
      rd[`CTL_RESUME] = s.resume;
      rd[`CTL_BQ2]    = s.bq2;
    end else if (avs_req.address == `ADR_STAT) begin
      rd[`ST_Q1FLG] = s.q1.flg;
      rd[`ST_Q2FLG] = s.q2.flg;
      rd[`ST_Q1ST]  = s.q1.st;
      rd[`ST_Q2ST]  = s.q2.st;
    end
  end

  // ========================================================================
  // next state
  always_comb begin
    n = s;
    n.cmd.start = 1'b0;
    n.cmd.abort = 1'b0;
    // two-stage trigger synchronisers
    n.t1s = trig1;
    n.t1  = s.t1s;
    n.t1d = s.t1;
    n.t2s = trig2;
    n.t2  = s.t2s;
    n.t2d = s.t2;

    // bus: clears first so that hardware sets below win
    n.rsp.waitrequest = !acc;
    if (acc && avs_req.read) begin
      n.rsp.readdata = rd;
    end
    if (acc && avs_req.write) begin
      if (avs_req.address < `ADR_CCW_END) begin
        n.conversion_command_word[avs_req.address[5:0]] = avs_req.writedata[`CCW_BITS];   // see [R01]
      end else if (avs_req.address == `ADR_Q1CTL) begin
        n.q1.mode = avs_req.writedata[`CTL_MODE];
        n.q1.sse  = avs_req.writedata[`CTL_SSE];
      end else if (avs_req.address == `ADR_Q2CTL) begin
        n.q2.mode = avs_req.writedata[`CTL_MODE];
        n.q2.sse  = avs_req.writedata[`CTL_SSE];
        n.resume  = avs_req.writedata[`CTL_RESUME];
        n.bq2     = avs_req.writedata[`CTL_BQ2];
      end else if (avs_req.address == `ADR_STAT) begin
        n.q1.flg = s.q1.flg & ~avs_req.writedata[`ST_Q1FLG];   // see [R25]
        n.q2.flg = s.q2.flg & ~avs_req.writedata[`ST_Q2FLG];
      end
    end

    // engine: fetch a word, convert it, store the result
    qn = s.run2 ? n.q2 : n.q1;
    unique case (s.eng)
      e_idle: begin
        if (s.q1.st == q_active) begin                 // see [R02]
          n.run2 = 1'b0;
          n.eng  = e_fetch;
        end else if (s.q2.st == q_active) begin
          n.run2 = 1'b1;
          n.eng  = e_fetch;
        end
      end
      e_fetch: begin
        if (cur_eoq) begin                             // see [R21]
          qn.flg.cf = 1'b1;
          qn.st     = q_idle;
          qn.sse    = 1'b0;
          qn.ptr    = s.run2 ? s.bq2 : '0;             // see [R14]
          n.eng     = e_idle;
          n.after_pause = 1'b0;
        end else if (s.after_pause) begin
          qn.st = q_paused;                            // see [R15] see [R12]
          n.eng = e_idle;
          n.after_pause = 1'b0;
        end else begin
          n.cmd.start   = 1'b1;
          n.cmd.channel = cur_cw[`CCW_CHAN];
          n.eng         = e_conv;
        end
      end
      e_conv: begin
        if (conv_done) begin
          n.res[qn.ptr] = conv_result;
          qn.ptr = qn.ptr + 6'h01;                     // see [R12]
          if (cur_cw[`CCW_PAUSE]) begin                // see [R10]
            qn.flg.pf = 1'b1;                          // see [R20]
            n.after_pause = 1'b1;
          end
          n.eng = e_fetch;
        end
      end
    endcase
    if (s.eng != e_idle) begin
      if (s.run2) begin
        n.q2 = qn;
      end else begin
        n.q1 = qn;
      end
    end

    // queue 1 triggers
    if (ev1) begin
      if (s.q1.st == q_idle || s.q1.st == q_paused) begin   // see [R03]
        if (s.q1.st == q_idle) begin
          n.q1.ptr = '0;
        end
        n.q1.sub = n.q1.ptr;
        n.q1.st  = q_active;
        if (n.q2.st == q_active) begin
          n.q2.st = q_suspended;                       // see [R06]
          if (n.eng != e_idle && n.run2) begin
            n = abort_run(n, s.eng == e_conv);
          end
        end
      end else begin
        n.q1.flg.tor = 1'b1;                           // see [R13]
      end
    end

    // queue 2 triggers, judged after queue 1 so a tie leaves it pending
    if (ev2) begin
      if (s.q2.st == q_idle || s.q2.st == q_paused) begin
        if (s.q2.st == q_idle) begin
          n.q2.ptr = s.bq2;                            // see [R17]
        end
        n.q2.sub = n.q2.ptr;
        n.q2.st  = (n.q1.st == q_active) ? q_pending : q_active;   // see [R04] see [R09]
      end else begin
        n.q2.flg.tor = 1'b1;                           // see [R05] see [R07] see [R13]
      end
    end

    // queue 2 resumes once queue 1 completes or pauses
    if (n.q1.st != q_active && (n.q2.st == q_pending || n.q2.st == q_suspended)) begin
      if (n.q2.st == q_suspended && !s.resume) begin
        n.q2.ptr = n.q2.sub;                           // see [R08]
      end
      n.q2.st = q_active;
    end

    // disabled or reserved modes hold the queue inactive
    if (!mode_ok(s.q1.mode)) begin
      n.q1.st = q_idle;                                // see [R22]
      if (n.eng != e_idle && !n.run2) begin
        n = abort_run(n, s.eng == e_conv);
      end
    end
    if (!mode_ok(s.q2.mode)) begin
      n.q2.st = q_idle;                                // see [R22]
      if (n.eng != e_idle && n.run2) begin
        n = abort_run(n, s.eng == e_conv);
      end
    end
  end

  // ========================================================================
  // state register; prescaler lives elsewhere, safe to change when idle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s <= '0;
      s.rsp.waitrequest <= 1'b1;
    end else if (ce) begin
      s <= n;                                          // see [R24]
    end
  end

  assign avs_rsp = s.rsp;
  assign conv    = s.cmd;

  // ========================================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst || !ce);

  sequence seq_eoq_fetch;
    s.eng == e_fetch && cur_eoq;
  endsequence

  sequence seq_done_idle;
    !conv.start && s.eng == e_idle && cur_q.flg.cf;
  endsequence

  sequence seq_pause_done;
    s.eng == e_conv && conv_done && cur_cw[`CCW_PAUSE];
  endsequence

  a_q1_priority: assert property (   // see [R02]
    (s.eng != e_idle && s.run2) |-> s.q1.st != q_active)
    else $error("queue 2 runs while queue 1 is active");

  a_pend_hold: assert property (   // see [R04]
    $rose(s.q2.st == q_active) |-> s.q1.st != q_active)
    else $error("queue 2 started under active queue 1");

  a_q2_overrun: assert property (   // see [R05]
    (ev2 && (s.q2.st == q_pending || s.q2.st == q_suspended)) |=> s.q2.flg.tor)
    else $error("queue 2 overrun not recorded");

  a_abort_susp: assert property (   // see [R06]
    (ev1 && (s.q1.st == q_idle || s.q1.st == q_paused) && s.q2.st == q_active
     && s.run2 && s.eng == e_conv) |=> conv.abort && s.q2.st == q_suspended)
    else $error("queue 2 not aborted and suspended");

  a_simul_trig: assert property (   // see [R09]
    (ev1 && ev2 && (s.q1.st == q_idle || s.q1.st == q_paused)
     && (s.q2.st == q_idle || s.q2.st == q_paused))
    |=> s.q1.st == q_active && s.q2.st == q_pending)
    else $error("simultaneous triggers mishandled");

  a_eoq_no_conv: assert property (   // see [R16]
    seq_eoq_fetch |=> seq_done_idle)
    else $error("end of queue converted or not completed");

  a_pause_flag: assert property (   // see [R15]
    seq_pause_done |=> cur_q.flg.pf)
    else $error("pause flag missing after pause word");

  a_pause_eoq: assert property (   // see [R20]
    seq_pause_done ##1 seq_eoq_fetch |=> cur_q.flg.pf && cur_q.flg.cf && cur_q.st == q_idle)
    else $error("pause before end of queue not idle with both flags");

  a_mode_off: assert property (   // see [R22]
    !mode_ok(s.q1.mode) |=> s.q1.st == q_idle)
    else $error("disabled queue 1 not inactive");

  a_no_wait: assert property (   // see [R23]
    (req && s.rsp.waitrequest && s.eng == e_idle) |=> !s.rsp.waitrequest)
    else $error("idle engine stalled the bus");

  a_flag_sticky: assert property (   // see [R25]
    (s.q1.flg.cf && !(acc && avs_req.write && avs_req.address == `ADR_STAT
     && avs_req.writedata[`ST_Q1_CF])) |=> s.q1.flg.cf)
    else $error("completion flag lost without clear");

  a_q1_start: assert property (   // see [R03]
    (ev1 && s.q1.st == q_idle) |=> s.q1.st == q_active)
    else $error("triggered idle queue 1 did not start");

  a_q2_resume: assert property (   // see [R08]
    (s.q2.st == q_suspended && !s.run2 && s.eng == e_fetch && cur_eoq && !ev1
     && mode_ok(s.q2.mode)) |=> s.q2.st == q_active)
    else $error("suspended queue 2 not resumed after queue 1");

endmodule

// *** conv_model.sv ***
`timescale 1ns/1ns
// ==========================================================================
// converter stand-in on the far side of the sequencer
module conv_model (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        nrst,
  // command from the sequencer, latency from the testbench
  input  wire sequencer_pkg::conv_cmd_type conv,
  input  wire logic [7:0]                  lat,
  // answer to the sequencer
  output logic                             conv_done,
  output sequencer_pkg::result_type        conv_result
);
  import sequencer_pkg::*;
  logic [7:0] cnt;
  logic       busy;
  ptr_type    chan;
  // one conversion outstanding; result toggles off the done cycle so stale data never matches
  always_ff @(posedge clock) begin
    conv_done   <= 1'b0;
    conv_result <= ~conv_result;
    if (!nrst) begin
      busy        <= 1'b0;
      cnt         <= 8'h00;
      chan        <= 6'h00;
      conv_result <= 10'h000;
    end else if (conv.abort) begin
      busy <= 1'b0; // aborted work never answers
    end else if (conv.start) begin
      busy <= 1'b1;
      cnt  <= lat;
      chan <= conv.channel;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      if (cnt <= 8'h01) begin
        busy        <= 1'b0;
        conv_done   <= 1'b1;
        conv_result <= {4'h5, chan};
      end
    end
  end
endmodule

// *** sequencer_consts.svh ***
`ifndef SEQUENCER_CONSTS_SVH
`define SEQUENCER_CONSTS_SVH
// ==========================================================================
// table sizes and command word fields
`define TBL_ENTRIES    40
`define TBL_END        6'h28
`define EOQ_CODE       6'h3f
`define CCW_CHAN       5:0
`define CCW_PAUSE      6
`define CCW_BITS       6:0
`define RES_BITS       9:0
// ==========================================================================
// word addresses on the register bus
`define ADR_CCW_END    7'h28
`define ADR_RES        7'h40
`define ADR_RES_END    7'h68
`define ADR_Q1CTL      7'h70
`define ADR_Q2CTL      7'h71
`define ADR_STAT       7'h72
// ==========================================================================
// control and status fields
`define CTL_MODE       2:0
`define CTL_SSE        3
`define CTL_RESUME     4
`define CTL_BQ2        13:8
`define ST_Q1FLG       2:0
`define ST_Q1_CF       2
`define ST_Q2FLG       5:3
`define ST_Q1ST        10:8
`define ST_Q2ST        14:12
// ==========================================================================
// queue operating modes, all other codes reserved
`define MODE_DISABLED  3'h0
`define MODE_SW_SINGLE 3'h1
`define MODE_EX_SINGLE 3'h2
`define MODE_SW_CONT   3'h3
`define MODE_EX_CONT   3'h4
`endif

// *** sequencer_pkg.sv ***
`include "sequencer_consts.svh"
package sequencer_pkg;
  // ========================================================================
  // basic words
  typedef logic [6:0] ccw_type;
  typedef logic [9:0] result_type;
  typedef logic [5:0] ptr_type;
  // ========================================================================
  // states
  typedef enum logic [2:0] {q_idle, q_active, q_paused, q_suspended, q_pending} qstat_type;
  typedef enum logic [1:0] {e_idle, e_fetch, e_conv} eng_type;
  // ========================================================================
  // carriers
  typedef struct packed {
    logic cf;
    logic pf;
    logic tor;
  } flags_type;
  typedef struct packed {
    ptr_type   ptr;
    ptr_type   sub;
    qstat_type st;
    flags_type flg;
    logic      sse;
    logic [2:0] mode;
  } queue_type;
  typedef struct packed {
    logic [6:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avs_req_type;
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avs_rsp_type;
  typedef struct packed {
    logic    start;
    logic    abort;
    ptr_type channel;
  } conv_cmd_type;
  typedef struct packed {
    ccw_type    [`TBL_ENTRIES-1:0] conversion_command_word;
    result_type [`TBL_ENTRIES-1:0] res;
    queue_type    q1;
    queue_type    q2;
    eng_type      eng;
    logic         run2;
    logic         after_pause;
    logic         resume;
    ptr_type      bq2;
    logic         t1s;
    logic         t1;
    logic         t1d;
    logic         t2s;
    logic         t2;
    logic         t2d;
    avs_rsp_type  rsp;
    conv_cmd_type cmd;
  } state_type;
endpackage

// *** tb_adc_queue_sequencer.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_adc_queue_sequencer;
  import sequencer_pkg::*;
  // ========================================================================
  // signals
  logic         clock, nrst, ce, trig1, trig2, conv_done;
  avs_req_type  req;
  avs_rsp_type  rsp;
  conv_cmd_type conv;
  result_type   conv_result;
  logic [7:0]   lat;
  logic [31:0]  s;
  int           error_cnt, samples_checked, aborts;
  ptr_type      chans[$];
  // ========================================================================
  // design and converter
  adc_queue_sequencer dut (.clock(clock), .nrst(nrst), .ce(ce), .avs_req(req),
    .avs_rsp(rsp), .trig1(trig1), .trig2(trig2), .conv(conv), .conv_done(conv_done),
    .conv_result(conv_result));
  conv_model cm (.clock(clock), .nrst(nrst), .conv(conv), .lat(lat),
    .conv_done(conv_done), .conv_result(conv_result));
  // clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // log of started channels and aborts
  always @(posedge clock) begin
    if (conv.start === 1'b1) chans.push_back(conv.channel);
    if (conv.abort === 1'b1) aborts++;
  end
  // ========================================================================
  // bus and trigger helpers
  task automatic bus(input logic wr_en, input logic [6:0] a, input logic [31:0] d,
                     output logic [31:0] q, output int n);
    @(posedge clock);
    req <= '{a, !wr_en, wr_en, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 500);
    q = rsp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
    if (n >= 500) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    int n;
    bus(1'b1, a, d, q, n);
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] q);
    int n;
    bus(1'b0, a, 32'h0000_0000, q, n);
  endtask
  // pulse long enough for the two-flop synchroniser to see the edge
  task automatic fire(input logic [1:0] m);
    @(posedge clock);
    trig1 <= m[0];
    trig2 <= m[1];
    repeat (4) @(posedge clock);
    trig1 <= 1'b0;
    trig2 <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // poll status, bounded, and compare the masked value
  task automatic wst(input logic [31:0] m, input logic [31:0] v);
    int i;
    i = 0;
    do begin
      rd(7'h72, s);
      i++;
    end while ((s & m) !== v && i < 300);
    `CHK(s & m, v)
  endtask
  // ========================================================================
  // scenarios
  task automatic t_reset;
    int n;
    logic [31:0] q;
    rd(7'h72, s); `CHK(s, 32'h0000_0000)
    rd(7'h7f, s); `CHK(s, 32'h0000_0000)
    rd(7'h28, s); `CHK(s, 32'h0000_0000)
    bus(1'b0, 7'h00, 32'h0000_0000, q, n); `CHK(n, 2)
    wr(7'h27, 32'h0000_0055);
    bus(1'b0, 7'h27, 32'h0000_0000, q, n); `CHK(q, 32'h0000_0055)
    `CHK(n, 2)
    wr(7'h40, 32'h0000_03ff);
    rd(7'h40, s); `CHK(s, 32'h0000_0000)
    $display("t_reset done");
  endtask
  task automatic t_disabled;
    logic [2:0] modes[4] = '{3'h0, 3'h5, 3'h6, 3'h7};
    wr(7'h00, 32'h0000_0003);
    foreach (modes[i]) begin
      wr(7'h70, {28'h0, 1'b1, modes[i]});
      fire(2'b01);
      rd(7'h72, s); `CHK(s[10:8], 3'h0)
      `CHK(chans.size(), 0)
    end
    wr(7'h70, 32'h0000_0000);
    $display("t_disabled done");
  endtask
  task automatic t_subqueue;
    lat = 8'd30;
    wr(7'h01, 32'h0000_0045);
    wr(7'h02, 32'h0000_0007);
    wr(7'h03, 32'h0000_003f);
    wr(7'h71, 32'h0000_1000);
    wr(7'h70, 32'h0000_000a);
    fire(2'b01);
    fire(2'b01); // lands while the subqueue runs
    wst(32'h0000_0202, 32'h0000_0202);
    `CHK(chans.size(), 2)
    `CHK({chans[0], chans[1]}, 12'h0c5)
    rd(7'h72, s); `CHK(s[0], 1'b1)
    rd(7'h41, s); `CHK(s, 32'h0000_0145)
    fire(2'b01);
    wst(32'h0000_0706, 32'h0000_0006);
    `CHK(chans.size(), 3)
    `CHK(chans[2], 6'h07)
    wr(7'h70, 32'h0000_0004);
    fire(2'b01);
    wst(32'h0000_0200, 32'h0000_0200);
    `CHK(chans[3], 6'h03)
    wr(7'h70, 32'h0000_0000);
    $display("t_subqueue done");
  endtask
  task automatic t_eoq;
    logic [31:0] first[3] = '{32'h7f, 32'h03, 32'h3f};
    logic [31:0] bq[3] = '{32'h1000, 32'h0000, 32'h0000};
    lat = 8'd8;
    // table rewritten only while the engine rests
    foreach (first[i]) begin
      chans.delete();
      wr(7'h00, first[i]);
      wr(7'h71, bq[i]);
      wr(7'h72, 32'h0000_003f);
      wr(7'h70, 32'h0000_000a);
      fire(2'b01);
      wst(32'h0000_0706, 32'h0000_0004);
      `CHK(chans.size(), 0)
    end
    wr(7'h00, 32'h0000_0043);
    wr(7'h01, 32'h0000_003f);
    wr(7'h71, 32'h0000_1000);
    wr(7'h72, 32'h0000_003f);
    wr(7'h70, 32'h0000_000a);
    fire(2'b01);
    wst(32'h0000_0706, 32'h0000_0006);
    `CHK(chans.size(), 1)
    chans.delete();
    wr(7'h71, 32'h0000_300a);
    fire(2'b10);
    wst(32'h0000_7038, 32'h0000_0020);
    `CHK(chans.size(), 0)
    $display("t_eoq done");
  endtask
  task automatic t_priority;
    lat = 8'd40;
    wr(7'h00, 32'h0000_0001);
    wr(7'h01, 32'h0000_0002);
    wr(7'h02, 32'h0000_003f);
    wr(7'h04, 32'h0000_0009);
    wr(7'h05, 32'h0000_000a);
    wr(7'h06, 32'h0000_003f);
    wr(7'h71, 32'h0000_040a);
    wr(7'h70, 32'h0000_000a);
    wr(7'h72, 32'h0000_003f);
    chans.delete();
    aborts = 0;
    fire(2'b11);
    wst(32'h0000_7700, 32'h0000_4100);
    fire(2'b10);
    rd(7'h72, s); `CHK(s[3], 1'b1)
    wst(32'h0000_7000, 32'h0000_1000);
    `CHK({chans[0], chans[1]}, 12'h042)
    wr(7'h70, 32'h0000_000a);
    wr(7'h72, 32'h0000_003f);
    fire(2'b01);
    wst(32'h0000_7000, 32'h0000_3000);
    `CHK(aborts, 1)
    fire(2'b10);
    rd(7'h72, s); `CHK(s[3], 1'b1)
    wst(32'h0000_7020, 32'h0000_0020);
    `CHK(chans.size(), 7)
    `CHK({chans[2], chans[5], chans[6]}, 18'h0924a)
    $display("t_priority done");
  endtask
  // software started modes: single runs once, continuous keeps rescanning
  task automatic t_sw_modes;
    int n0;
    n0 = chans.size();
    wr(7'h72, 32'h0000_003f);
    wr(7'h70, 32'h0000_0009);
    wst(32'h0000_0704, 32'h0000_0004);
    `CHK(chans.size(), n0 + 2)
    lat = 8'd8;
    wr(7'h70, 32'h0000_0003);
    repeat (300) @(posedge clock);
    wr(7'h70, 32'h0000_0000);
    `CHK(chans.size() > n0 + 6, 1'b1)
    rd(7'h72, s); `CHK(s[10:8], 3'h0)
    $display("t_sw_modes done");
  endtask
  // ========================================================================
  // verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog, well above the roughly 1100 cycles the tests need
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    nrst  = 1'b0;
    ce    = 1'b1;
    trig1 = 1'b0;
    trig2 = 1'b0;
    req   = '0;
    lat   = 8'd8;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_disabled();
    t_subqueue();
    t_eoq();
    t_priority();
    t_sw_modes();
    final_report();
  end
endmodule
